// file: logic/ulw_cache.sv
// Design decisions made here: strobed register access and the address map.
`timescale 1ns/1ps
`include "ulw_cfg.svh"

module ulw_cache
  import ulw_pkg::*;
#(
  parameter int NENT = 8,
  parameter int GUEST_AW = 48,
  parameter int DIDW = 16,
  parameter int PASW = 20
) (
  // clock and reset
  input  wire logic              mclk,
  input  wire logic              rst_b,
  // register port
  input  wire logic [7:0]        reg_addr,
  input  wire logic [31:0]       reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [31:0]       reg_rdata,
  // lookup request
  input  wire logic              lk_valid,
  input  wire logic [1:0]        lk_mode,
  input  wire logic [DIDW-1:0]   lk_did,
  input  wire logic [PASW-1:0]   lk_pasid,
  input  wire logic [63:0]       lk_addr,
  // lookup answer
  output logic                   lk_done,
  output logic                   lk_hit_top,
  output logic                   lk_hit_ptr,
  output logic      [39:0]       lk_next,
  output logic      [4:0]        lk_perm,
  // fill from the walker
  input  wire logic              fl_valid,
  input  wire logic              fl_lvl,
  input  wire logic [1:0]        fl_mode,
  input  wire logic              fl_fault,
  input  wire logic [DIDW-1:0]   fl_did,
  input  wire logic [PASW-1:0]   fl_pasid,
  input  wire logic [63:0]       fl_addr,
  input  wire logic [63:0]       fl_up_raw,
  input  wire logic [63:0]       fl_cur_raw,
  input  wire logic [39:0]       fl_sl_addr,
  input  wire logic              fl_sl_r,
  input  wire logic              fl_sl_w,
  input  wire logic              fl_sl_x,
  input  wire logic              fl_sl_up_r,
  input  wire logic              fl_sl_up_w,
  // fill answer
  output logic                   fl_done,
  output logic                   fl_cached,
  output logic      [1:0]        fl_acc_set
);

  localparam int TW = GUEST_AW - `ULW_PTR_SH;
  localparam int IW = (NENT > 1) ? $clog2(NENT) : 1;

  // tag slice by level and mode; bits above the mode's width read as zero
  function automatic logic [TW-1:0] tag_of(input logic [63:0] a, input logic l,
                                           input logic [1:0] m);
    int sh;
    int hi;
    sh = l ? `ULW_PTR_SH : `ULW_TOP_SH;
    hi = (m == ULW_SL) ? GUEST_AW : `ULW_FL_TOP;
    tag_of = '0;
    for (int i = 0; i < TW; i++) begin
      if ((i < hi - sh) && (i + sh < 64)) tag_of[i] = a[i + sh];
    end
  endfunction

  // ==========================================================
  // registers
  logic [`ULW_CTRL_W-1:0] ctrl;
  logic [15:0]            hits;
  logic [15:0]            fills;

  // control: cache enables, execute and accessed enables, caching mode
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl <= `ULW_CTRL_RST;
    end else if (reg_wr && reg_addr == `ULW_CTRL_OFS) begin
      ctrl <= reg_wdata[`ULW_CTRL_W-1:0];
    end
  end

  // read data stands only in the cycle after the strobe; unmapped reads zero
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      unique case (reg_addr)
        `ULW_CTRL_OFS:  reg_rdata <= {{(32-`ULW_CTRL_W){1'b0}}, ctrl};
        `ULW_HITS_OFS:  reg_rdata <= {16'h0000, hits};
        `ULW_FILLS_OFS: reg_rdata <= {16'h0000, fills};
        default:        reg_rdata <= '0;
      endcase
    end else begin
      reg_rdata <= '0;
    end
  end

  // ==========================================================
  // entry array, shared by both levels and all mapping kinds
  logic [NENT-1:0]  e_v;
  logic             e_lvl   [NENT];
  logic [1:0]       e_mode  [NENT];
  logic [DIDW-1:0]  e_did   [NENT];
  logic [PASW-1:0]  e_pasid [NENT];
  logic [TW-1:0]    e_tag   [NENT];
  logic [39:0]      e_addr  [NENT];
  logic [4:0]       e_perm  [NENT];
  logic [NENT-1:0]  m_top;
  logic [NENT-1:0]  m_ptr;

  // per entry match: kind, domain, PASID unless second stage, tag
  for (genvar g = 0; g < NENT; g++) begin : g_match
    logic hit;
    assign hit = e_v[g] && e_mode[g] == lk_mode && e_did[g] == lk_did
                 && (e_mode[g] == ULW_SL || e_pasid[g] == lk_pasid)
                 && e_tag[g] == tag_of(lk_addr, e_lvl[g], e_mode[g]);
    assign m_top[g] = hit && !e_lvl[g] && ctrl[`ULW_C_EN_TOP];
    assign m_ptr[g] = hit && e_lvl[g] && ctrl[`ULW_C_EN_PTR];
  end

  // ==========================================================
  // lookup: pointer hit wins since it skips both fetches
  logic [39:0] next_addr;
  logic [4:0]  next_perm;

  always_comb begin
    next_addr = '0;
    next_perm = '0;
    for (int i = 0; i < NENT; i++) begin
      if (m_top[i] && m_ptr == '0) begin
        next_addr = e_addr[i];
        next_perm = e_perm[i];
      end
    end
    for (int i = 0; i < NENT; i++) begin
      if (m_ptr[i]) begin
        next_addr = e_addr[i];
        next_perm = e_perm[i];
      end
    end
  end

  // answer one cycle after the request; a miss tells the walker to fetch
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      lk_done    <= 1'b0;
      lk_hit_top <= 1'b0;
      lk_hit_ptr <= 1'b0;
      lk_next    <= '0;
      lk_perm    <= '0;
    end else begin
      lk_done    <= lk_valid;
      lk_hit_top <= lk_valid && m_top != '0 && m_ptr == '0;
      lk_hit_ptr <= lk_valid && m_ptr != '0;
      lk_next    <= next_addr;
      lk_perm    <= next_perm;
    end
  end

  // ==========================================================
  // fill decode
  logic            isptr;
  logic            page;
  logic            rsv_ok;
  logic            pres;
  logic            rw_ok;
  logic            na_cu;
  logic            na_up;
  logic            acc_ok;
  logic            strict_ok;
  logic            create;
  logic            zero_tag;
  logic [4:0]      next_eperm;
  logic [39:0]     next_eaddr;
  logic [IW-1:0]   victim;

  always_comb begin
    isptr  = fl_lvl == ULW_PTR;
    // the top entry of a pointer fill is checked too
    page   = fl_cur_raw[`ULW_B_PS] || (isptr && fl_up_raw[`ULW_B_PS]);
    rsv_ok = fl_cur_raw[`ULW_RSV_HI:`ULW_RSV_LO] == '0
             && (!isptr || fl_up_raw[`ULW_RSV_HI:`ULW_RSV_LO] == '0);
    pres   = fl_cur_raw[`ULW_B_P] && (!isptr || fl_up_raw[`ULW_B_P]);
    rw_ok  = (fl_cur_raw[`ULW_B_R] || fl_cur_raw[`ULW_B_W])
             && (!isptr || fl_up_raw[`ULW_B_R] || fl_up_raw[`ULW_B_W]);
    // accessed flags still clear; set by the walker before use
    na_cu  = !fl_cur_raw[`ULW_B_A] || (ctrl[`ULW_C_XACC_EN] && !fl_cur_raw[`ULW_B_EA]);
    na_up  = isptr && (!fl_up_raw[`ULW_B_A]
             || (ctrl[`ULW_C_XACC_EN] && !fl_up_raw[`ULW_B_EA]));
    acc_ok = fl_mode != ULW_NS
             || ((!na_cu || fl_sl_w) && (!na_up || fl_sl_up_w));
    if (fl_mode == ULW_SL) begin
      strict_ok = rsv_ok && rw_ok;
    end else begin
      strict_ok = rsv_ok && pres && acc_ok
                  && (fl_mode != ULW_NS || (fl_sl_r && (!isptr || fl_sl_up_r)));
    end
    // next-level contents are not examined, so empty tables still cache
    create = fl_valid && !page
             && (isptr ? ctrl[`ULW_C_EN_PTR] : ctrl[`ULW_C_EN_TOP])
             && (ctrl[`ULW_C_CMODE] || (!fl_fault && strict_ok));
    zero_tag = ctrl[`ULW_C_CMODE] && fl_fault
               && !((fl_mode == ULW_SL) ? rw_ok : pres);
  end

  // stored permissions per mapping kind
  always_comb begin
    next_eperm = '0;
    next_eaddr = fl_cur_raw[`ULW_ADDR_HI:`ULW_ADDR_LO];
    if (fl_mode == ULW_SL) begin
      next_eperm[`ULW_P_RD] = fl_cur_raw[`ULW_B_R] && (!isptr || fl_up_raw[`ULW_B_R]);
      next_eperm[`ULW_P_WR] = fl_cur_raw[`ULW_B_W] && (!isptr || fl_up_raw[`ULW_B_W]);
      next_eperm[`ULW_P_XB] = ctrl[`ULW_C_S2X_EN]
                              && !(fl_cur_raw[`ULW_B_X] && (!isptr || fl_up_raw[`ULW_B_X]));
    end else begin
      next_eperm[`ULW_P_WR] = fl_cur_raw[`ULW_B_RW] && (!isptr || fl_up_raw[`ULW_B_RW]);
      next_eperm[`ULW_P_RD] = fl_cur_raw[`ULW_B_US] && (!isptr || fl_up_raw[`ULW_B_US]);
      next_eperm[`ULW_P_XB] = ctrl[`ULW_C_NOEX_EN]
                              && (fl_cur_raw[`ULW_B_NOEX] || (isptr && fl_up_raw[`ULW_B_NOEX]));
      next_eperm[`ULW_P_CDIS] = fl_cur_raw[`ULW_B_CDIS];
      next_eperm[`ULW_P_WTHR] = fl_cur_raw[`ULW_B_WTHR];
      if (fl_mode == ULW_NS) begin
        next_eaddr = fl_sl_addr;
        next_eperm[`ULW_P_WR] = next_eperm[`ULW_P_WR] && fl_sl_w;
        next_eperm[`ULW_P_XB] = next_eperm[`ULW_P_XB]
                                || (ctrl[`ULW_C_S2X_EN] && !fl_sl_x);
      end
    end
  end

  // ==========================================================
  // entry valid bits and round-robin victim; no memory snoop exists
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      e_v    <= '0;
      victim <= '0;
    end else if (create) begin
      e_v[victim] <= 1'b1;
      victim      <= (victim == IW'(NENT - 1)) ? '0 : victim + 1'b1;
    end
  end

  // entry payload; needs no reset, guarded by the valid bits
  always_ff @(posedge mclk) begin
    if (create) begin
      e_lvl[victim]   <= fl_lvl;
      e_mode[victim]  <= fl_mode;
      e_did[victim]   <= zero_tag ? '0 : fl_did;
      e_pasid[victim] <= (zero_tag || fl_mode == ULW_SL) ? '0 : fl_pasid;
      e_tag[victim]   <= tag_of(fl_addr, fl_lvl, fl_mode);
      e_addr[victim]  <= next_eaddr;
      e_perm[victim]  <= next_eperm;
    end
  end

  // fill answer; accessed-set requests only for faultless first-level kinds
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      fl_done    <= 1'b0;
      fl_cached  <= 1'b0;
      fl_acc_set <= '0;
    end else begin
      fl_done    <= fl_valid;
      fl_cached  <= create;
      fl_acc_set <= (create && !fl_fault && fl_mode != ULW_SL)
                    ? {na_up, na_cu}
                    : 2'b00;
    end
  end

  // statistics counters, wrap on overflow
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      hits  <= '0;
      fills <= '0;
    end else begin
      hits  <= hits + 16'(lk_valid && (m_top != '0 || m_ptr != '0));
      fills <= fills + 16'(create);
    end
  end

  // ==========================================================
  // checks
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);

  sequence s_page_fill;
    fl_valid && fl_cur_raw[`ULW_B_PS];
  endsequence
  sequence s_fl_absent;
    fl_valid && fl_mode == ULW_FL && !ctrl[`ULW_C_CMODE] && !fl_cur_raw[`ULW_B_P];
  endsequence
  sequence s_sl_norw;
    fl_valid && fl_mode == ULW_SL && !ctrl[`ULW_C_CMODE]
    && !fl_cur_raw[`ULW_B_R] && !fl_cur_raw[`ULW_B_W];
  endsequence
  sequence s_ns_noread;
    fl_valid && fl_mode == ULW_NS && !ctrl[`ULW_C_CMODE] && !fl_sl_r;
  endsequence

  page_never_cached_a: assert property (s_page_fill |=> !fl_cached)
    else $error("page-mapping entry was cached");
  absent_fl_a: assert property (s_fl_absent |=> !fl_cached)
    else $error("non-present first-level entry was cached");
  sl_no_rw_a: assert property (s_sl_norw |=> !fl_cached)
    else $error("second-stage entry without R or W was cached");
  ns_read_perm_a: assert property (s_ns_noread |=> !fl_cached)
    else $error("nested entry cached without stage-2 read");
  acc_set_req_a: assert property (fl_valid && fl_mode == ULW_FL && !fl_lvl
      && !fl_fault && !fl_cur_raw[`ULW_B_A] && create |=> fl_acc_set[0] && fl_cached)
    else $error("accessed bit set not requested before caching");
  cm_fault_fill_a: assert property (fl_valid && ctrl[`ULW_C_CMODE] && fl_fault
      && !fl_cur_raw[`ULW_B_PS] && !fl_up_raw[`ULW_B_PS] && ctrl[1:0] == 2'b11
      |=> fl_cached)
    else $error("caching mode fill refused");
  top_disabled_a: assert property (lk_valid && !ctrl[`ULW_C_EN_TOP]
      |=> lk_done && !lk_hit_top)
    else $error("disabled top-level cache hit");
  fill_then_hit_a: assert property (fl_valid && fl_lvl && fl_mode == ULW_FL && create
      && !fl_fault ##1 (lk_valid && lk_mode == ULW_FL && ctrl[`ULW_C_EN_PTR]
      && lk_did == $past(fl_did) && lk_pasid == $past(fl_pasid)
      && lk_addr[47:30] == $past(fl_addr[47:30]))
      |=> lk_hit_ptr)
    else $error("fresh pointer entry missed");

endmodule  // ulw_cache

// file: shared/ulw_cfg.svh
`ifndef ULW_CFG_SVH
`define ULW_CFG_SVH
// register offsets (byte addresses) and reset value
`define ULW_CTRL_OFS  8'h00
`define ULW_HITS_OFS  8'h04
`define ULW_FILLS_OFS 8'h08
`define ULW_CTRL_RST  6'h03
`define ULW_CTRL_W    6
// control fields
`define ULW_C_EN_TOP  0
`define ULW_C_EN_PTR  1
`define ULW_C_NOEX_EN 2
`define ULW_C_S2X_EN  3
`define ULW_C_XACC_EN 4
`define ULW_C_CMODE   5
// walk entry fields, first-level format
`define ULW_B_P       0
`define ULW_B_RW      1
`define ULW_B_US      2
`define ULW_B_WTHR    3
`define ULW_B_CDIS    4
`define ULW_B_A       5
`define ULW_B_PS      7
`define ULW_B_EA      10
`define ULW_B_NOEX    63
// walk entry fields, second-stage format
`define ULW_B_R       0
`define ULW_B_W       1
`define ULW_B_X       2
// next-table address and reserved span
`define ULW_ADDR_HI   51
`define ULW_ADDR_LO   12
`define ULW_RSV_HI    62
`define ULW_RSV_LO    52
// tag shifts and first-level top bound
`define ULW_TOP_SH    39
`define ULW_PTR_SH    30
`define ULW_FL_TOP    48
// stored permission vector
`define ULW_P_WR      0
`define ULW_P_RD      1
`define ULW_P_XB      2
`define ULW_P_CDIS    3
`define ULW_P_WTHR    4
`define ULW_PW        5
`endif

// file: shared/ulw_pkg.sv
package ulw_pkg;
  // mapping kind of a walk or lookup
  typedef enum logic [1:0] {
    ULW_FL = 2'b00,
    ULW_SL = 2'b01,
    ULW_NS = 2'b11
  } ulw_mode_e;
  // which upper level an entry caches
  typedef enum logic {
    ULW_TOP = 1'b0,
    ULW_PTR = 1'b1
  } ulw_lvl_e;
endpackage

// file: testbench/tb_ulw_cache.sv
`timescale 1ns/1ps
`include "ulw_cfg.svh"
// self-checking bench: register port, walker fills and lookups
module tb_ulw_cache import ulw_pkg::*; ;
  // ==========================================
  // signals and constants
  logic        mclk, rst_b, reg_wr, reg_rd, lk_valid, lk_done, lk_hit_top, lk_hit_ptr;
  logic        fl_valid, fl_lvl, fl_fault, fl_done, fl_cached, go;
  logic        fl_sl_r, fl_sl_w, fl_sl_x, fl_sl_up_r, fl_sl_up_w;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  logic [1:0]  lk_mode, fl_mode, fl_acc_set;
  logic [15:0] lk_did, fl_did;
  logic [19:0] lk_pasid, fl_pasid;
  logic [63:0] lk_addr, fl_addr, fl_up_raw, fl_cur_raw;
  logic [39:0] lk_next, fl_sl_addr;
  logic [4:0]  lk_perm;
  int          n_fail, n_tests, n_hit, n_fill;
  localparam logic [15:0] D   = 16'h0011;
  localparam logic [19:0] P   = 20'h00022;
  localparam logic [39:0] SLO = 40'h00100;
  localparam logic [63:0] A   = 64'h0000_0081_4000_0000;
  localparam logic [63:0] B30 = 64'h4000_0000;
  localparam logic [63:0] B31 = 64'h8000_0000;
  localparam logic [63:0] B39 = 64'h80_0000_0000;
  localparam logic [63:0] B40 = 64'h100_0000_0000;
  localparam logic [63:0] B41 = 64'h200_0000_0000;
  localparam logic [63:0] B48 = 64'h1_0000_0000_0000;
  localparam logic [63:0] B52 = 64'h10_0000_0000_0000;
  localparam logic [63:0] TG  = 64'h8000_000a_bcde_f03f; // p, rw, us, wt, cd, a, no-exec
  localparam logic [63:0] PE  = 64'h0000_0000_1234_502d; // p, us, wt, a
  localparam logic [63:0] S0  = 64'h0000_0000_5555_6000; // stage-2 entry, no rights
  localparam logic [63:0] TN  = 64'h0000_0000_7777_8027; // present, rw, us, a

  ulw_cache uut (.mclk, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .lk_valid, .lk_mode, .lk_did, .lk_pasid, .lk_addr, .lk_done, .lk_hit_top, .lk_hit_ptr,
    .lk_next, .lk_perm, .fl_valid, .fl_lvl, .fl_mode, .fl_fault, .fl_did, .fl_pasid,
    .fl_addr, .fl_up_raw, .fl_cur_raw, .fl_sl_addr, .fl_sl_r, .fl_sl_w, .fl_sl_x,
    .fl_sl_up_r, .fl_sl_up_w, .fl_done, .fl_cached, .fl_acc_set);
  ulw_walker #(.SL_OFS(SLO)) wk (.mclk, .rst_b, .go, .lvl(fl_lvl), .addr(fl_addr),
    .fl_done, .fl_acc_set, .fl_valid, .fl_up_raw, .fl_cur_raw, .fl_sl_addr, .fl_sl_r,
    .fl_sl_w, .fl_sl_x, .fl_sl_up_r, .fl_sl_up_w);

  // ==========================================
  // clock and tasks
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 check(reg_rdata, exp);
  endtask
  // exp is {accessed request, cached}
  task automatic fill(input logic lv, input logic [1:0] md, input logic [63:0] a,
                      input logic flt, input logic [2:0] exp);
    @(posedge mclk);
    go <= 1'b1;
    fl_lvl <= lv;
    fl_mode <= md;
    fl_addr <= a;
    fl_fault <= flt;
    @(posedge mclk);
    go <= 1'b0;
    @(posedge mclk);
    #1 check({fl_done, fl_acc_set, fl_cached}, {1'b1, exp});
    n_fill += exp[0];
  endtask
  // hit is {pointer, top}; msk selects the permission bits that are compared
  task automatic look(input logic [1:0] md, input logic [63:0] a, input logic [15:0] d,
                      input logic [19:0] p, input logic [1:0] hit, input logic [39:0] nx,
                      input logic [4:0] pm, input logic [4:0] msk);
    @(posedge mclk);
    lk_valid <= 1'b1;
    lk_mode <= md;
    lk_addr <= a;
    lk_did <= d;
    lk_pasid <= p;
    @(posedge mclk);
    lk_valid <= 1'b0;
    #1 check({lk_done, lk_hit_ptr, lk_hit_top, lk_next, lk_perm & msk},
             {1'b1, hit, nx, pm & msk});
    n_hit += (hit != 2'b00);
  endtask
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // a hung handshake would otherwise stall the run for good
  initial begin
    #25000;
    n_fail++;
    final_report();
  end

  // ==========================================
  // tests
  initial begin
    {rst_b, go, reg_wr, reg_rd, lk_valid, fl_lvl, fl_fault} = '0;
    {reg_addr, reg_wdata, lk_mode, fl_mode, lk_addr, fl_addr} = '0;
    {lk_did, fl_did, lk_pasid, fl_pasid} = {D, D, P, P};
    {n_fail, n_tests, n_hit, n_fill} = '0;
    for (int i = 0; i < 8; i++) begin
      wk.top_mem[i] = '0;
      wk.ptr_mem[i] = '0;
    end
    wk.s2_cur = 3'b111;
    wk.s2_up = 2'b11;
    repeat (6) @(posedge mclk);
    rst_b <= 1'b1;
    rd(`ULW_CTRL_OFS, 32'h3);
    rd(8'h0c, 32'h0);
    wr(`ULW_HITS_OFS, 32'hffff);
    rd(`ULW_HITS_OFS, 32'h0);
    $display("test registers done");
    wk.top_mem[1] = TG | 64'h80;
    fill(1'b0, ULW_FL, A, 1'b0, 3'b000);
    wk.top_mem[1] = TG & ~64'h1;
    fill(1'b0, ULW_FL, A, 1'b0, 3'b000);
    wk.top_mem[1] = TG | B52;
    fill(1'b0, ULW_FL, A, 1'b0, 3'b000);
    wk.top_mem[1] = TG;
    fill(1'b0, ULW_FL, A, 1'b0, 3'b001);
    look(ULW_FL, A, D, P, 2'b01, TG[51:12], 5'h1b, 5'h1f);
    look(ULW_FL, A ^ B39, D, P, 2'b00, 40'h0, 5'h0, 5'h0);
    look(ULW_FL, A, D ^ 16'h1, P, 2'b00, 40'h0, 5'h0, 5'h0);
    look(ULW_FL, A, D, P ^ 20'h1, 2'b00, 40'h0, 5'h0, 5'h0);
    $display("test top level done");
    wr(`ULW_CTRL_OFS, 32'h07);
    wk.ptr_mem[5] = PE;
    fill(1'b1, ULW_FL, A, 1'b0, 3'b001);
    look(ULW_FL, A, D, P, 2'b10, PE[51:12], 5'h16, 5'h1f);
    look(ULW_FL, A ^ B30, D, P, 2'b01, TG[51:12], 5'h0, 5'h0);
    wk.top_mem[1] = TG | B52;
    wk.ptr_mem[6] = PE;
    fill(1'b1, ULW_FL, A ^ B30 ^ B31, 1'b0, 3'b000);
    look(ULW_FL, A ^ B30 ^ B31, D, P, 2'b01, TG[51:12], 5'h0, 5'h0);
    wk.top_mem[1] = TG;
    $display("test pointer level done");
    wr(`ULW_CTRL_OFS, 32'h17);
    wk.top_mem[2] = TG & ~64'h20;
    fill(1'b0, ULW_FL, A ^ B39 ^ B40, 1'b0, 3'b011);
    look(ULW_FL, A ^ B39 ^ B40, D, P, 2'b01, TG[51:12], 5'h0, 5'h0);
    fill(1'b1, ULW_FL, A ^ B39 ^ B40, 1'b0, 3'b011);
    // top flag still clear: only the top entry is asked for; lookup the cycle after the fill
    wk.top_mem[7] = TG;
    fork
      fill(1'b1, ULW_FL, A ^ B40 ^ B41, 1'b0, 3'b101);
      begin
        repeat (2) @(posedge mclk);
        look(ULW_FL, A ^ B40 ^ B41, D, P, 2'b10, PE[51:12], 5'h16, 5'h1f);
      end
    join
    $display("test accessed flags done");
    wr(`ULW_CTRL_OFS, 32'h0b);
    wk.top_mem[3] = S0;
    fill(1'b0, ULW_SL, A ^ B40, 1'b0, 3'b000);
    wk.top_mem[3] = S0 | 64'h5;
    fill(1'b0, ULW_SL, A ^ B40, 1'b0, 3'b001);
    look(ULW_SL, A ^ B40, D, P ^ 20'h1, 2'b01, S0[51:12], 5'h02, 5'h07);
    fill(1'b1, ULW_SL, A ^ B40, 1'b0, 3'b001);
    look(ULW_SL, A ^ B40, D, P, 2'b10, PE[51:12], 5'h02, 5'h07);
    $display("test second stage done");
    wr(`ULW_CTRL_OFS, 32'h0f);
    wk.top_mem[4] = TN;
    wk.s2_cur = 3'b000;
    fill(1'b0, ULW_NS, A ^ B39 ^ B41, 1'b0, 3'b000);
    wk.s2_cur = 3'b001;
    fill(1'b0, ULW_NS, A ^ B39 ^ B41, 1'b0, 3'b001);
    look(ULW_NS, A ^ B39 ^ B41, D, P, 2'b01, TN[51:12] + SLO, 5'h06, 5'h07);
    look(ULW_NS, A ^ B39 ^ B41 ^ B48, D, P, 2'b01, TN[51:12] + SLO, 5'h0, 5'h0);
    $display("test nested done");
    wr(`ULW_CTRL_OFS, 32'h23);
    wk.top_mem[6] = 64'h20;
    @(posedge mclk);
    fl_did <= 16'h0005;
    fl_pasid <= 20'h00007;
    fill(1'b0, ULW_FL, A ^ B39 ^ B40 ^ B41, 1'b1, 3'b001);
    look(ULW_FL, A ^ B39 ^ B40 ^ B41, 16'h0, 20'h0, 2'b01, 40'h0, 5'h0, 5'h0);
    look(ULW_FL, A ^ B39 ^ B40 ^ B41, 16'h5, 20'h7, 2'b00, 40'h0, 5'h0, 5'h0);
    wr(`ULW_CTRL_OFS, 32'h02);
    look(ULW_FL, A ^ B30, D, P, 2'b00, 40'h0, 5'h0, 5'h0);
    $display("test caching mode done");
    rd(`ULW_HITS_OFS, 32'(n_hit));
    rd(`ULW_FILLS_OFS, 32'(n_fill));
    $display("test counters done");
    final_report();
  end
endmodule // tb_ulw_cache

// file: testbench/ulw_walker.sv
`timescale 1ns/1ps
// behavioural walker: entry tables, stage-2 rights and accessed-flag writes
module ulw_walker #(
  parameter logic [39:0] SL_OFS = 40'h00100
) (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_b,
  // walk request from the bench
  input  wire logic        go,
  input  wire logic        lvl,
  input  wire logic [63:0] addr,
  // fill port of the cache
  input  wire logic        fl_done,
  input  wire logic [1:0]  fl_acc_set,
  output logic             fl_valid,
  output logic      [63:0] fl_up_raw,
  output logic      [63:0] fl_cur_raw,
  output logic      [39:0] fl_sl_addr,
  output logic             fl_sl_r,
  output logic             fl_sl_w,
  output logic             fl_sl_x,
  output logic             fl_sl_up_r,
  output logic             fl_sl_up_w
);
  // tables and stage-2 rights, loaded by the bench
  logic [63:0] top_mem [8];
  logic [63:0] ptr_mem [8];
  logic [2:0]  s2_cur;
  logic [1:0]  s2_up;
  logic [2:0]  it;
  logic [2:0]  ip;
  // entries stay presented while the bench holds addr and lvl
  assign it = addr[41:39];
  assign ip = addr[32:30];
  assign fl_up_raw = top_mem[it];
  assign fl_cur_raw = lvl ? ptr_mem[ip] : top_mem[it];
  // stage-2 translation is a fixed offset: enough to tell it from the raw address
  assign fl_sl_addr = fl_cur_raw[51:12] + SL_OFS;
  assign {fl_sl_x, fl_sl_w, fl_sl_r} = s2_cur;
  assign {fl_sl_up_w, fl_sl_up_r} = s2_up;
  // one fill pulse per request
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      fl_valid <= 1'b0;
    end else begin
      fl_valid <= go;
    end
  end
  // the walker performs the flag writes that the cache asks for
  always @(posedge mclk) begin
    if (fl_done && fl_acc_set[0] && lvl) begin
      ptr_mem[ip] <= ptr_mem[ip] | 64'h420;
    end
    if (fl_done && (fl_acc_set[1] || (fl_acc_set[0] && !lvl))) begin
      top_mem[it] <= top_mem[it] | 64'h420;
    end
  end
endmodule // ulw_walker
